// ---- logic/cpq_pkg.sv ----
/*
  shared constants and types for the period / quadrature position counter:
  register offsets, control and status field layout, modes and carriers.
  assumes a 32-bit axi4-lite register bus with byte addresses.
*/
`default_nettype none
package cpq_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SYNC_STAGES = 3;
  localparam int NUM_INPUTS = 5;

  // byte offsets of the register words
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SAMPLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RELOAD = 8'h14;

  // control word field positions (mirrored by cpq_ctrl_s)
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_ENC_LSB = 3;
  localparam int CTRL_GATE_FALL_BIT = 5;
  localparam int CTRL_SRC_FALL_BIT = 6;
  localparam int CTRL_SMP_FALL_BIT = 7;
  localparam int CTRL_BUF_EN_BIT = 8;
  localparam int CTRL_IDX_EN_BIT = 9;
  localparam int CTRL_IDX_PHASE_LSB = 10;

  // status word bit positions
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_RUNNING_BIT = 1;
  localparam int ST_RESULT_VALID_BIT = 2;
  localparam int ST_SAMPLE_VALID_BIT = 3;
  localparam int ST_OVERRUN_BIT = 4;

  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RELOAD_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COUNT_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // input order in the synchroniser bank
  localparam int IN_GATE = 0;
  localparam int IN_SRC = 1;
  localparam int IN_A = 2;
  localparam int IN_B = 3;
  localparam int IN_Z = 4;

  typedef enum logic [1:0] {MODE_PERIOD, MODE_QUAD, MODE_TWO_PULSE, MODE_SPARE} cpq_mode_e;
  typedef enum logic [1:0] {ENC_X1, ENC_X2, ENC_X4, ENC_SPARE} cpq_enc_e;
  typedef enum logic [1:0] {PER_IDLE, PER_WAIT, PER_COUNT} cpq_per_e;

  typedef struct packed {
    logic [19:0] spare;
    logic [1:0] idxPhase;
    logic idxEn;
    logic bufEn;
    logic smpFall;
    logic srcFall;
    logic gateFall;
    cpq_enc_e enc;
    cpq_mode_e mode;
    logic arm;
  } cpq_ctrl_s;

  typedef struct packed {
    logic lvl;
    logic rise;
    logic fall;
  } cpq_edge_s;
endpackage
`default_nettype wire

// ---- logic/cpq_sync_edge.sv ----
/*
  one input pin: three-stage synchroniser, agreement filter and edge pulses.
  assumes the pin is asynchronous to ref_clk and slower than two clock periods.
*/
`timescale 1ns/1ps
`default_nettype none
module cpq_sync_edge
  import cpq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic pinIn,
  output cpq_edge_s edgeOut
);
  logic [SYNC_STAGES-1:0] sync_q;
  logic level_q;
  logic rise_q;
  logic fall_q;
  wire logic agree = (sync_q[1] == sync_q[2]);
  wire logic change = agree && (sync_q[2] != level_q);

  // first stage feeds only the second; level moves when stages two and three agree [R15]
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sync_q <= '0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (ce) begin
      sync_q <= {sync_q[1:0], pinIn};
      if (change) begin
        level_q <= sync_q[2];
      end
      rise_q <= change && sync_q[2]; // [R15]
      fall_q <= change && !sync_q[2];
    end
  end

  assign edgeOut = '{lvl: level_q, rise: rise_q, fall: fall_q};
endmodule
`default_nettype wire

// ---- logic/cpq_quad_dec.sv ----
/*
  step decoder for quadrature x1/x2/x4 and two-pulse encoders.
  assumes filtered levels and one-cycle edge pulses from the synchroniser bank.
*/
`timescale 1ns/1ps
`default_nettype none
module cpq_quad_dec
  import cpq_pkg::*;
(
  input wire cpq_mode_e mode,
  input wire cpq_enc_e enc,
  input wire cpq_edge_s chA,
  input wire cpq_edge_s chB,
  output logic stepUp,
  output logic stepDown
);
  // a rising while b low means a leads; a falling while b low means b leads
  wire logic aUp = (chA.rise && !chB.lvl) || (chA.fall && chB.lvl);
  wire logic aDown = (chA.rise && chB.lvl) || (chA.fall && !chB.lvl);
  wire logic bUp = (chB.rise && chA.lvl) || (chB.fall && !chA.lvl);
  wire logic bDown = (chB.rise && !chA.lvl) || (chB.fall && chA.lvl);
  wire logic x1Up = chA.rise && !chB.lvl; // [R7]
  wire logic x1Down = chA.fall && !chB.lvl; // [R8]
  // both pulses in one cycle cancel, so neither step is taken
  wire logic tpUp = chA.rise && !chB.rise; // [R12]
  wire logic tpDown = chB.rise && !chA.rise; // [R12]

  always_comb begin
    stepUp = 1'b0;
    stepDown = 1'b0;
    if (mode == MODE_TWO_PULSE) begin
      stepUp = tpUp; // [R11]
      stepDown = tpDown;
    end else if (mode == MODE_QUAD) begin
      case (enc)
        ENC_X1: begin
          stepUp = x1Up;
          stepDown = x1Down;
        end
        ENC_X2: begin
          stepUp = aUp; // [R9]
          stepDown = aDown;
        end
        ENC_X4: begin
          stepUp = aUp || bUp; // [R10]
          stepDown = aDown || bDown;
        end
        default: begin
          stepUp = 1'b0;
          stepDown = 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- logic/cpq_counter.sv ----
/*
  period and position counter with an axi4-lite register slave.
  assumes ref_clk at 200 MHz, a synchronous active-low reset, and gate,
  source and encoder pins asynchronous to ref_clk.
*/
// The address map and the AXI4-Lite slave port are this design's own decisions.
// Contract
// R1: armed period mode measures one gate period
// R2: active gate edge selectable, rising or falling
// R3: count chosen source edges between gate edges
// R4: position counts only after software arms
// R5: on-demand count read and sample-clock buffering
// R6: encoder inputs phase a, b, index
// R7: x1: a leads, up on a rise
// R8: x1: b leads, down on a fall
// R9: x2: step on both a edges
// R10: x4: step on every a and b edge
// R11: two-pulse encoders also accepted
// R12: two-pulse: a rise up, b rise down
// R13: index in chosen phase reloads; steps win
// R14: sample on chosen clock edge, no reset
// R15: pins synchronised, edges from synchronised signals
`timescale 1ns/1ps
`default_nettype none
module cpq_counter
  import cpq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic gateIn,
  input wire logic sourceIn,
  input wire logic phaseAIn,
  input wire logic phaseBIn,
  input wire logic indexIn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // merge a write word into a register under the byte strobes
  function automatic logic [DATA_W-1:0] strobeMerge(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] data,
                                                    input logic [3:0] strb);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // true when an address names one of the mapped words
  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    return (addr == OFF_CTRL) || (addr == OFF_STATUS) || (addr == OFF_COUNT) ||
           (addr == OFF_RESULT) || (addr == OFF_SAMPLE) || (addr == OFF_RELOAD);
  endfunction

  // synchroniser bank: gate, source, a, b, index [R6] [R15]
  logic [NUM_INPUTS-1:0] pins;
  cpq_edge_s edges [NUM_INPUTS];
  assign pins = {indexIn, phaseBIn, phaseAIn, sourceIn, gateIn};

  for (genvar g = 0; g < NUM_INPUTS; g++) begin : gSync
    cpq_sync_edge uSync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .ce(ce),
      .pinIn(pins[g]),
      .edgeOut(edges[g])
    );
  end

  // register state
  logic [DATA_W-1:0] ctrlWord_q;
  logic [DATA_W-1:0] reload_q;
  logic [DATA_W-1:0] count_q;
  logic [DATA_W-1:0] perCnt_q;
  logic [DATA_W-1:0] result_q;
  logic [DATA_W-1:0] sample_q;
  logic armed_q;
  logic resultValid_q;
  logic sampleValid_q;
  logic overrun_q;
  cpq_per_e perState_q;
  cpq_ctrl_s ctrl;
  assign ctrl = cpq_ctrl_s'(ctrlWord_q);

  // axi write and read channel state
  logic awHeld_q;
  logic wHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [DATA_W-1:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [DATA_W-1:0] rdata_q;

  // readies are held low while frozen so no beat is taken and lost
  assign s_axi_awready = ce && !awHeld_q && !bvalid_q;
  assign s_axi_wready = ce && !wHeld_q && !bvalid_q;
  assign s_axi_arready = ce && !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  wire logic awTake = s_axi_awvalid && s_axi_awready;
  wire logic wTake = s_axi_wvalid && s_axi_wready;
  wire logic arTake = s_axi_arvalid && s_axi_arready;
  wire logic wrFire = ce && awHeld_q && wHeld_q && !bvalid_q;
  wire logic wrCtrl = wrFire && (awAddr_q == OFF_CTRL);
  wire logic wrStatus = wrFire && (awAddr_q == OFF_STATUS);
  wire logic wrReload = wrFire && (awAddr_q == OFF_RELOAD);
  wire logic [DATA_W-1:0] ctrlNext = strobeMerge(ctrlWord_q, wData_q, wStrb_q);
  wire logic [DATA_W-1:0] statusClr = strobeMerge('0, wData_q, wStrb_q);
  // arming happens on a write that sets the arm bit while idle; clearing it disarms
  wire logic armReq = wrCtrl && wStrb_q[0] && ctrlNext[CTRL_ARM_BIT] && !armed_q;
  wire logic disarmReq = wrCtrl && wStrb_q[0] && !ctrlNext[CTRL_ARM_BIT];

  // axi handshakes: address and data in either order, response after both
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (awTake) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read mux; count gives the on-demand position read [R5]
  wire logic [DATA_W-1:0] statusWord = {27'h000_0000, overrun_q, sampleValid_q, resultValid_q,
                                        perState_q == PER_COUNT, armed_q};
  logic [DATA_W-1:0] readMux;
  assign readMux = (s_axi_araddr == OFF_CTRL) ? {ctrlWord_q[DATA_W-1:1], armed_q} :
                   (s_axi_araddr == OFF_STATUS) ? statusWord :
                   (s_axi_araddr == OFF_COUNT) ? count_q :
                   (s_axi_araddr == OFF_RESULT) ? result_q :
                   (s_axi_araddr == OFF_SAMPLE) ? sample_q :
                   (s_axi_araddr == OFF_RELOAD) ? reload_q : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else if (ce) begin
      if (arTake) begin
        rvalid_q <= 1'b1;
        rdata_q <= readMux;
        rresp_q <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // control and reload words
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrlWord_q <= CTRL_RESET;
      reload_q <= RELOAD_RESET;
    end else if (ce) begin
      if (wrCtrl) begin
        ctrlWord_q <= ctrlNext;
      end
      if (wrReload) begin
        reload_q <= strobeMerge(reload_q, wData_q, wStrb_q);
      end
    end
  end

  // selected edges
  wire logic gateEdge = ctrl.gateFall ? edges[IN_GATE].fall : edges[IN_GATE].rise; // [R2]
  wire logic srcEdge = ctrl.srcFall ? edges[IN_SRC].fall : edges[IN_SRC].rise; // [R3]
  // the sample clock shares the gate pin, with its own polarity choice
  wire logic smpEdge = ctrl.smpFall ? edges[IN_GATE].fall : edges[IN_GATE].rise; // [R14]
  wire logic isPeriod = (ctrl.mode == MODE_PERIOD);
  wire logic perDone = armed_q && isPeriod && (perState_q == PER_COUNT) && gateEdge;

  logic stepUp;
  logic stepDown;
  cpq_quad_dec uDec (
    .mode(ctrl.mode),
    .enc(ctrl.enc),
    .chA(edges[IN_A]),
    .chB(edges[IN_B]),
    .stepUp(stepUp),
    .stepDown(stepDown)
  );

  // arm state: software arms, a finished period or a disarm write drops it
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      armed_q <= 1'b0;
    end else if (ce) begin
      if (armReq) begin
        armed_q <= 1'b1;
      end else if (disarmReq || perDone) begin
        armed_q <= 1'b0; // single period, then idle [R1]
      end
    end
  end

  // period sequencer: wait for first active gate edge, count, stop at the next
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      perState_q <= PER_IDLE;
      perCnt_q <= '0;
      result_q <= '0;
    end else if (ce) begin
      if (armReq && ctrlNext[CTRL_MODE_LSB +: 2] == MODE_PERIOD) begin
        perState_q <= PER_WAIT; // nothing happens before arming [R1]
        perCnt_q <= '0;
      end else if (!armed_q || !isPeriod) begin
        perState_q <= PER_IDLE;
      end else begin
        case (perState_q)
          PER_WAIT: begin
            if (gateEdge) begin
              perState_q <= PER_COUNT; // [R2]
              perCnt_q <= '0;
            end
          end
          PER_COUNT: begin
            if (gateEdge) begin
              // a source edge coinciding with the closing gate edge still counts
              result_q <= perCnt_q + {31'h0000_0000, srcEdge}; // [R3]
              perState_q <= PER_IDLE;
            end else if (srcEdge) begin
              perCnt_q <= perCnt_q + 32'h0000_0001; // [R3]
            end
          end
          default: begin
            perState_q <= PER_IDLE;
          end
        endcase
      end
    end
  end

  // position count: zeroed at arm, steps only while armed, index reload below steps
  wire logic posRun = armed_q && !isPeriod; // [R4]
  wire logic idxPhaseHit = ({edges[IN_A].lvl, edges[IN_B].lvl} == ctrl.idxPhase);
  wire logic idxReload = posRun && ctrl.idxEn && (ctrl.mode == MODE_QUAD) && edges[IN_Z].lvl &&
                         idxPhaseHit;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      count_q <= COUNT_RESET;
    end else if (ce) begin
      if (armReq) begin
        count_q <= COUNT_RESET; // samples are cumulative from this point [R14]
      end else if (posRun && stepUp) begin
        count_q <= count_q + 32'h0000_0001; // [R4]
      end else if (posRun && stepDown) begin
        count_q <= count_q - 32'h0000_0001;
      end else if (idxReload) begin
        count_q <= reload_q; // [R13]
      end
    end
  end

  // buffered sampling and sticky flags; a hardware set wins over a clear
  wire logic smpTake = posRun && ctrl.bufEn && smpEdge; // [R5]
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sample_q <= '0;
      sampleValid_q <= 1'b0;
      overrun_q <= 1'b0;
      resultValid_q <= 1'b0;
    end else if (ce) begin
      if (smpTake) begin
        sample_q <= count_q; // count itself is not reset [R14]
      end
      sampleValid_q <= smpTake || (sampleValid_q && !(wrStatus && statusClr[ST_SAMPLE_VALID_BIT]));
      overrun_q <= (smpTake && sampleValid_q) ||
                   (overrun_q && !(wrStatus && statusClr[ST_OVERRUN_BIT]));
      resultValid_q <= perDone || (resultValid_q && !(wrStatus && statusClr[ST_RESULT_VALID_BIT]));
    end
  end
endmodule
`default_nettype wire

// ---- sim/cpq_counter_asserts.sv ----
/* checker for the register bus handshakes of cpq_counter.
   assumes it is bound onto cpq_counter and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module cpq_counter_asserts
  import cpq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // a transfer is taken on the edge where valid meets ready
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_rd_latency: assert property (
    s_rd_take |=> s_axi_rvalid) else $error("read answer late");
  chk_wr_latency: assert property (
    s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off time");
  chk_rd_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_wr_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_ar_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer pending");
  chk_aw_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while answer pending");
  chk_bad_addr: assert property (
    (s_rd_take and s_axi_araddr > OFF_RELOAD) |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_ce_freeze: assert property (
    !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready) else $error("ready while frozen");
endmodule
bind cpq_counter cpq_counter_asserts cpq_counter_asserts_i (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ---- sim/cpq_enc_model.sv ----
/* encoder, gate and source pin model for the counter bench.
   assumes each task is entered right after a rising edge of ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module cpq_enc_model
  import cpq_pkg::*;
(
  input wire logic ref_clk,
  output logic gateIn,
  output logic sourceIn,
  output logic phaseAIn,
  output logic phaseBIn,
  output logic indexIn
);
  // six cycles a level: above the minimum spacing the synchroniser needs
  localparam int HOLD = 6;
  initial begin
    gateIn = 1'b0;
    sourceIn = 1'b0;
    phaseAIn = 1'b0;
    phaseBIn = 1'b0;
    indexIn = 1'b0;
  end
  // change one pin, then hold it
  task automatic set_pin(input int which, input logic v);
    case (which)
      IN_GATE: gateIn <= v;
      IN_SRC: sourceIn <= v;
      IN_A: phaseAIn <= v;
      IN_B: phaseBIn <= v;
      default: indexIn <= v;
    endcase
    repeat (HOLD) @(posedge ref_clk);
  endtask
  // one quadrature cycle, a leading b when fwd is set
  task automatic cycle(input logic fwd);
    set_pin(fwd ? IN_A : IN_B, 1'b1);
    set_pin(fwd ? IN_B : IN_A, 1'b1);
    set_pin(fwd ? IN_A : IN_B, 1'b0);
    set_pin(fwd ? IN_B : IN_A, 1'b0);
  endtask
  // one high pulse: two-pulse steps, source edges, sample clock
  task automatic pulse(input int which);
    set_pin(which, 1'b1);
    set_pin(which, 1'b0);
  endtask
endmodule
`default_nettype wire

// ---- sim/cpq_counter_tb.sv ----
/* self-checking bench for cpq_counter: register bus master and pin scenarios.
   assumes cpq_enc_model drives the pins and the checker is bound in. */
`timescale 1ns/1ps
`default_nettype none
module cpq_counter_tb;
  import cpq_pkg::*;
  logic ref_clk, resetn, ce, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [ADDR_W-1:0] awa, ara;
  logic [DATA_W-1:0] wd, rd;
  logic [1:0] bresp, rresp;
  logic [3:0] ws;
  logic [2:0] prot;
  wire gateIn, sourceIn, phaseAIn, phaseBIn, indexIn;
  int errors, cmp_count;
  cpq_enc_model cpq_enc_model_i (.ref_clk(ref_clk), .gateIn(gateIn), .sourceIn(sourceIn), .phaseAIn(phaseAIn),
    .phaseBIn(phaseBIn), .indexIn(indexIn));
  cpq_counter cpq_counter_i (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .gateIn(gateIn), .sourceIn(sourceIn),
    .phaseAIn(phaseAIn), .phaseBIn(phaseBIn), .indexIn(indexIn), .s_axi_awaddr(awa), .s_axi_awprot(prot),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arprot(prot), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ready flags are judged at the falling edge, so nothing races the rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awt, wt, bt, late;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    prot <= 3'($urandom());
    bt = 1'b0;
    for (int t = 0; t < 100 && !bt; t++) begin
      @(negedge ref_clk);
      awt = awv && awr;
      wt = wv && wr;
      late = bv && !br;
      bt = bv && br;
      r = bresp;
      @(posedge ref_clk);
      if (awt) awv <= 1'b0;
      if (wt) wv <= 1'b0;
      if (late) br <= 1'b1;
    end
    br <= 1'b0;
    check("write done", 32'(bt), 32'h0000_0001);
  endtask
  // rready comes a cycle after rvalid, so the answer must stand meanwhile
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic art, rt, late;
    ara <= a;
    arv <= 1'b1;
    rt = 1'b0;
    for (int t = 0; t < 100 && !rt; t++) begin
      @(negedge ref_clk);
      art = arv && arr;
      late = rv && !rr;
      rt = rv && rr;
      d = rd;
      r = rresp;
      @(posedge ref_clk);
      if (art) arv <= 1'b0;
      if (late) rr <= 1'b1;
    end
    rr <= 1'b0;
    check("read done", 32'(rt), 32'h0000_0001);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    check(what, d, exp);
  endtask
  // control word for an armed run
  function automatic logic [31:0] ctl(input cpq_mode_e md, input int e, input int bits);
    cpq_ctrl_s c;
    c = cpq_ctrl_s'(32'(bits));
    c.arm = 1'b1;
    c.mode = md;
    c.enc = cpq_enc_e'(e);
    return c;
  endfunction
  // steps per quadrature cycle: one, two or four
  function automatic logic [31:0] exp_quad(input int e, input int n, input int m);
    return 32'((n - m) * (e == 0 ? 1 : (e == 1 ? 2 : 4)));
  endfunction
  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end
  initial begin
    logic [31:0] d, v;
    logic [1:0] r;
    int n, m;
    {awv, wv, br, arv, rr, awa, ara, wd, prot, errors, cmp_count} = '0;
    ws = 4'hF;
    resetn = 1'b0;
    ce = 1'b1;
    void'($urandom(36));
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rdchk("ctrl reset", OFF_CTRL, CTRL_RESET);
    rdchk("count reset", OFF_COUNT, COUNT_RESET);
    rdchk("reload reset", OFF_RELOAD, RELOAD_RESET);
    axr(8'h40, d, r);
    check("bad read", 32'(r), 32'(RESP_SLVERR));
    axw(8'h40, 32'h1234_5678, r);
    check("bad write", 32'(r), 32'(RESP_SLVERR));
    ce <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ce <= 1'b1;
    axw(OFF_CTRL, ctl(MODE_QUAD, 0, 0) & 32'hFFFF_FFFE, r);
    cpq_enc_model_i.cycle(1'b1);
    rdchk("unarmed", OFF_COUNT, 32'h0000_0000);
    $display("test bus and arm done");
    for (int e = 0; e < 3; e++) begin
      n = $urandom_range(4, 0);
      m = $urandom_range(4, 0);
      axw(OFF_CTRL, ctl(MODE_QUAD, e, 0), r);
      repeat (n) cpq_enc_model_i.cycle(1'b1);
      repeat (m) cpq_enc_model_i.cycle(1'b0);
      rdchk("quad count", OFF_COUNT, exp_quad(e, n, m));
      axw(OFF_CTRL, 32'h0000_0000, r);
    end
    n = $urandom_range(4, 0);
    m = $urandom_range(4, 0);
    axw(OFF_CTRL, ctl(MODE_TWO_PULSE, 0, 0), r);
    repeat (n) cpq_enc_model_i.pulse(IN_A);
    repeat (m) cpq_enc_model_i.pulse(IN_B);
    rdchk("two-pulse", OFF_COUNT, 32'(n - m));
    axw(OFF_CTRL, 32'h0000_0000, r);
    $display("test position done");
    // source edges outside the period must not count, and the inactive gate edge must not end the period
    for (int p = 0; p < 2; p++) begin
      n = $urandom_range(5, 1);
      m = $urandom_range(3, 0);
      axw(OFF_STATUS, 32'h0000_001C, r);
      rdchk("status clear", OFF_STATUS, 32'h0000_0000);
      cpq_enc_model_i.set_pin(IN_GATE, p[0]);
      cpq_enc_model_i.pulse(IN_SRC);
      axw(OFF_CTRL, ctl(MODE_PERIOD, 0, (p << CTRL_GATE_FALL_BIT) | ($urandom_range(1, 0) << CTRL_SRC_FALL_BIT)), r);
      cpq_enc_model_i.pulse(IN_SRC);
      cpq_enc_model_i.set_pin(IN_GATE, !p[0]);
      repeat (n) cpq_enc_model_i.pulse(IN_SRC);
      cpq_enc_model_i.set_pin(IN_GATE, p[0]);
      repeat (m) cpq_enc_model_i.pulse(IN_SRC);
      cpq_enc_model_i.set_pin(IN_GATE, !p[0]);
      cpq_enc_model_i.pulse(IN_SRC);
      rdchk("period", OFF_RESULT, 32'(n + m));
      axr(OFF_STATUS, d, r);
      check("armed after period", 32'(d[ST_ARMED_BIT]), 32'h0000_0000);
      check("result valid", 32'(d[ST_RESULT_VALID_BIT]), 32'h0000_0001);
    end
    cpq_enc_model_i.set_pin(IN_GATE, 1'b0);
    $display("test period done");
    n = $urandom_range(4, 1);
    m = $urandom_range(4, 1);
    axw(OFF_CTRL, ctl(MODE_QUAD, 0, (1 << CTRL_BUF_EN_BIT) | ($urandom_range(1, 0) << CTRL_SMP_FALL_BIT)), r);
    repeat (n) cpq_enc_model_i.cycle(1'b1);
    cpq_enc_model_i.pulse(IN_GATE);
    rdchk("sample one", OFF_SAMPLE, 32'(n));
    repeat (m) cpq_enc_model_i.cycle(1'b1);
    cpq_enc_model_i.pulse(IN_GATE);
    rdchk("sample two", OFF_SAMPLE, 32'(n + m));
    rdchk("live count", OFF_COUNT, 32'(n + m));
    axw(OFF_CTRL, 32'h0000_0000, r);
    $display("test buffered done");
    v = $urandom();
    axw(OFF_RELOAD, v, r);
    rdchk("reload reg", OFF_RELOAD, v);
    ws <= 4'h1;
    axw(OFF_RELOAD, ~v, r);
    ws <= 4'hF;
    v[7:0] = ~v[7:0];
    rdchk("reload strobe", OFF_RELOAD, v);
    axw(OFF_CTRL, ctl(MODE_QUAD, 0, 1 << CTRL_IDX_EN_BIT), r);
    cpq_enc_model_i.cycle(1'b1);
    cpq_enc_model_i.pulse(IN_Z);
    rdchk("reloaded", OFF_COUNT, v);
    cpq_enc_model_i.cycle(1'b1);
    rdchk("after reload", OFF_COUNT, v + 32'h0000_0001);
    $display("test index done");
    wrap_up();
  end
endmodule
`default_nettype wire
